// >>> src/slot_arb_pkg.sv
// shared constants and types for the expansion slot dma arbiter and card end
package slot_arb_pkg;
    // ------------------------------------------------------------
    // slot count and priority
    // ------------------------------------------------------------
    localparam int NUM_SLOTS      = 5;   // expansion slots 1..5
    localparam int NUM_REQ        = 6;   // index 0 is the coprocessor slot
    localparam int COPRO_LEVEL    = 0;   // coprocessor slot ranks above slot 1
    localparam int NO_WINNER      = 7;   // index meaning nobody granted
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_SYS_HZ     = 40000000;
    localparam int SYS7M_HZ       = 7000000;
    // divider count for the 7M sampling enable, rounded down (faster is safe)
    localparam int SYS7M_DIV      = (CLK_SYS_HZ / SYS7M_HZ < 1) ? 1 : CLK_SYS_HZ / SYS7M_HZ;
    localparam logic [2:0] NO_WINNER_IDX = 3'h7;

    typedef enum logic [1:0] {
        CARD_IDLE,
        CARD_REQUEST,
        CARD_OWN
    } card_state_t;
endpackage : slot_arb_pkg

// >>> src/slot_arb_if.sv
// interface joining the motherboard arbiter and the expansion card ends
`timescale 1ns/1ps
interface slot_arb_if;
    // active-low levels; wired-or lines are resolved from the enables
    logic [5:0] slot_bus_request_n;       // index 0 coprocessor slot
    logic [5:0] slot_bus_grant_n;
    logic       generic_bus_grant_n;
    logic       grant_ack_oe_card;        // card pulls grant_acknowledge low
    logic       grant_ack_oe_board;       // board pulls grant_acknowledge low
    logic       own_oe_card;              // card pulls ownership line low
    logic       address_strobe_n;
    logic       transfer_acknowledge_n;
    wire        grant_acknowledge_n;
    wire        own_n;

    // open-collector lines: low while anybody drives, else pulled high
    assign grant_acknowledge_n = ~(grant_ack_oe_card | grant_ack_oe_board);
    assign own_n               = ~own_oe_card;

    modport board (
        input  slot_bus_request_n,
        output slot_bus_grant_n,
        output generic_bus_grant_n,
        output grant_ack_oe_board,
        input  grant_acknowledge_n,
        input  own_n
    );
    modport card (
        output slot_bus_request_n,
        input  slot_bus_grant_n,
        input  generic_bus_grant_n,
        output grant_ack_oe_card,
        output own_oe_card,
        input  grant_acknowledge_n,
        input  own_n,
        input  address_strobe_n,
        input  transfer_acknowledge_n
    );
endinterface : slot_arb_if

// >>> src/slot_dma_arbiter.sv
// motherboard end: fixed-priority slot bus arbiter and generic grant mux
// Operation
// - card asserts ownership line when bus master
// - ownership line is wired-or, open-collector only
// - per-slot request/grant routed through priority logic
// - slot 1 highest, slot 5 lowest
// - idle coprocessor slot ranks level 0
// - requests registered on 7M rising edge
// - cards should clock requests synchronously too
// - card holds acknowledge for whole transfer
// - acknowledge waits for grant, strobes, acknowledge idle
// - acknowledge is wired-or, never driven high
// - basic variant passes processor grant unchanged
// - coprocessor variant muxes grant by controller
`timescale 1ns/1ps
module slot_dma_arbiter #(
    parameter int  NUM_SLOTS   = slot_arb_pkg::NUM_SLOTS,
    parameter int  SYS7M_DIV   = slot_arb_pkg::SYS7M_DIV,
    parameter bit  COPRO_BUILD = 1'b1
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    slot_arb_if.board bus,
    input  wire logic i_copro_mode,                // coprocessor slot acting as coprocessor
    input  wire logic i_copro_in_charge,           // coprocessor controls the bus
    input  wire logic i_processor_bus_grant_n,     // host processor grant
    input  wire logic i_coprocessor_bus_grant_n,   // coprocessor grant
    input  wire logic i_board_hold_ack,            // board logic claims grant_acknowledge
    output logic      o_processor_bus_request_n,   // to host processor request
    output logic      o_dma_owner                  // ownership line seen asserted
);
    // ------------------------------------------------------------
    // 7M sampling enable
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic       tick_7m;

    // one-cycle enable at the 7M rate from the single system clock
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == 8'(SYS7M_DIV - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign tick_7m = (div_cnt == 8'(SYS7M_DIV - 1));

    // ------------------------------------------------------------
    // request sampling and priority
    // ------------------------------------------------------------
    logic [NUM_SLOTS:0] req_q;
    logic [NUM_SLOTS:0] req_live;
    logic [2:0]         winner;
    logic [2:0]         next_winner;

    // requests sampled on the 7M edge so asynchronous cards cannot race
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q <= '0;
        end else if (tick_7m) begin
            req_q <= ~bus.slot_bus_request_n[NUM_SLOTS:0];
        end
    end

    // coprocessor slot joins the chain only while not a coprocessor
    always_comb begin
        req_live    = req_q;
        req_live[0] = req_q[0] & ~i_copro_mode;
    end

    // lowest index wins: 0 (coprocessor) then slot 1 down to slot 5
    function automatic logic [2:0] pick_highest(input logic [NUM_SLOTS:0] req);
        logic [2:0] idx;
        idx = slot_arb_pkg::NO_WINNER_IDX;
        for (int i = NUM_SLOTS; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : pick_highest

    // grant held until the winner drops its request, then re-arbitrate
    always_comb begin
        next_winner = winner;
        if (winner == slot_arb_pkg::NO_WINNER_IDX) begin
            next_winner = pick_highest(req_live);
        end else if (!req_live[winner]) begin
            next_winner = pick_highest(req_live);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            winner <= slot_arb_pkg::NO_WINNER_IDX;
        end else if (tick_7m) begin
            winner <= next_winner;
        end
    end

    // ------------------------------------------------------------
    // grant outputs
    // ------------------------------------------------------------
    logic [NUM_SLOTS:0] grant_q;
    logic               gbg_q;

    // a slot sees its grant only once the processor has granted the bus
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            grant_q <= '0;
        end else begin
            for (int i = 0; i <= NUM_SLOTS; i++) begin
                grant_q[i] <= (winner == 3'(i)) & ~i_processor_bus_grant_n;
            end
        end
    end

    // generic grant follows whichever processor holds the bus
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gbg_q <= 1'b1;
        end else if (COPRO_BUILD && i_copro_in_charge) begin
            gbg_q <= i_coprocessor_bus_grant_n;
        end else begin
            gbg_q <= i_processor_bus_grant_n;
        end
    end

    assign bus.slot_bus_grant_n      = ~grant_q;
    assign bus.generic_bus_grant_n   = gbg_q;
    // open-collector: only an enable, the line is never driven high
    assign bus.grant_ack_oe_board    = i_board_hold_ack;
    // request to the host while any slot is chosen
    assign o_processor_bus_request_n = (winner == slot_arb_pkg::NO_WINNER_IDX);
    assign o_dma_owner               = ~bus.own_n;
endmodule : slot_dma_arbiter

// >>> src/slot_dma_card.sv
// card end: expansion card acting as dma bus master on one slot
`timescale 1ns/1ps
module slot_dma_card #(
    parameter int SLOT      = 1,
    parameter int SYS7M_DIV = slot_arb_pkg::SYS7M_DIV
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    slot_arb_if.card  bus,
    input  wire logic i_dma_start,     // user wants a transfer (level)
    input  wire logic i_dma_done,      // user finished its transfer (pulse)
    output logic      o_bus_owned      // card is bus master
);
    // ------------------------------------------------------------
    // 7M enable for synchronous request output
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic       tick_7m;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= 8'h00;
        end else if (tick_7m) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign tick_7m = (div_cnt == 8'(SYS7M_DIV - 1));

    // ------------------------------------------------------------
    // mastership sequence
    // ------------------------------------------------------------
    slot_arb_pkg::card_state_t state;
    logic                      take_ok;

    // all previous masters gone before acknowledge is taken
    assign take_ok = ~bus.slot_bus_grant_n[SLOT] & bus.address_strobe_n
                   & bus.transfer_acknowledge_n & bus.grant_acknowledge_n;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= slot_arb_pkg::CARD_IDLE;
        end else begin
            case (state)
                slot_arb_pkg::CARD_IDLE: begin
                    // request goes out only on the 7M edge; release on i_dma_done is not tied to it
                    if (tick_7m && i_dma_start) begin
                        state <= slot_arb_pkg::CARD_REQUEST;
                    end
                end
                slot_arb_pkg::CARD_REQUEST: begin
                    if (take_ok) begin
                        state <= slot_arb_pkg::CARD_OWN;
                    end
                end
                slot_arb_pkg::CARD_OWN: begin
                    if (i_dma_done) begin
                        state <= slot_arb_pkg::CARD_IDLE;
                    end
                end
                default: begin
                    state <= slot_arb_pkg::CARD_IDLE;
                end
            endcase
        end
    end

    // request held through ownership so the arbiter keeps the grant
    always_comb begin
        bus.slot_bus_request_n       = '1;
        bus.slot_bus_request_n[SLOT] = (state == slot_arb_pkg::CARD_IDLE);
    end
    // open-collector drives: enables only
    assign bus.grant_ack_oe_card = (state == slot_arb_pkg::CARD_OWN);
    assign bus.own_oe_card       = (state == slot_arb_pkg::CARD_OWN);
    assign o_bus_owned           = (state == slot_arb_pkg::CARD_OWN);
endmodule : slot_dma_card

// >>> tb/slot_arb_sva.sv
// concurrent checks on the interface between the arbiter and the card
`timescale 1ns/1ps
module slot_arb_sva #(
    parameter int CARD_SLOT = 1
) (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic [5:0] slot_bus_request_n,
    input wire logic [5:0] slot_bus_grant_n,
    input wire logic       generic_bus_grant_n,
    input wire logic       grant_ack_oe_card,
    input wire logic       own_oe_card,
    input wire logic       address_strobe_n,
    input wire logic       transfer_acknowledge_n,
    input wire logic       grant_acknowledge_n,
    input wire logic       i_copro_mode,
    input wire logic       i_copro_in_charge,
    input wire logic       i_processor_bus_grant_n,
    input wire logic       i_coprocessor_bus_grant_n
);
    // ----------------------------------------
    // grant and acknowledge relations
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // a new grant needs a request seen on two edges, so it went through the register
    property p_req_first; (~slot_bus_grant_n & $past(slot_bus_grant_n)
        & ($past(slot_bus_request_n) | $past(slot_bus_request_n, 2))) == 6'h00; endproperty
    a_req_first: assert property (p_req_first) else $error("grant without request");
    property p_one_grant; $onehot0(~slot_bus_grant_n); endproperty
    a_one_grant: assert property (p_one_grant) else $error("two grants");
    property p_host_first; slot_bus_grant_n != 6'h3f |-> !$past(i_processor_bus_grant_n);
    endproperty
    a_host_first: assert property (p_host_first) else $error("grant without host");
    property p_copro_out; $fell(slot_bus_grant_n[0]) |-> !$past(i_copro_mode); endproperty
    a_copro_out: assert property (p_copro_out) else $error("copro slot granted");
    property p_grant_held; (~slot_bus_grant_n & ~slot_bus_request_n) != 6'h00
        && !i_processor_bus_grant_n |=> $stable(slot_bus_grant_n); endproperty
    a_grant_held: assert property (p_grant_held) else $error("grant moved");
    property p_generic; $past(i_rst_n) |-> generic_bus_grant_n == ($past(i_copro_in_charge)
        ? $past(i_coprocessor_bus_grant_n) : $past(i_processor_bus_grant_n)); endproperty
    a_generic: assert property (p_generic) else $error("generic grant wrong");
    // acknowledge only once the bus is quiet; ownership goes up with it
    property p_ack_cond; $rose(grant_ack_oe_card) |-> !$past(slot_bus_grant_n[CARD_SLOT])
        && $past(address_strobe_n) && $past(transfer_acknowledge_n)
        && $past(grant_acknowledge_n) && own_oe_card; endproperty
    a_ack_cond: assert property (p_ack_cond) else $error("early acknowledge");
    property p_release; $fell(grant_ack_oe_card) |-> slot_bus_request_n[CARD_SLOT]
        && !own_oe_card; endproperty
    a_release: assert property (p_release) else $error("release incomplete");
endmodule : slot_arb_sva

// >>> tb/tb_top.sv
// bench: card and arbiter joined, plus a basic arbiter fed by the bench
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst_n, dma_start, dma_done, copro_mode, copro_in_charge;
    logic host_grant_n, copro_grant_n, bus_owned, owner_a, owner_b, host_req_a_n, host_req_b_n;
    logic board_hold_ack;
    int   fails;
    int   compares;
    slot_arb_if bus_a ();
    slot_arb_if bus_b ();
    // ----------------------------------------
    // ends under test; bus_b requests come straight from the bench
    // ----------------------------------------
    // card sits in the coprocessor slot and keeps its own 7M divider, off the board's phase
    slot_dma_card #(.SLOT(0)) u_slot_dma_card (.i_clk_sys(clk_sys),
        .i_rst_n(rst_n), .bus(bus_a), .i_dma_start(dma_start), .i_dma_done(dma_done),
        .o_bus_owned(bus_owned));
    slot_dma_arbiter #(.SYS7M_DIV(1)) u_slot_dma_arbiter (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .bus(bus_a), .i_copro_mode(copro_mode), .i_copro_in_charge(copro_in_charge),
        .i_processor_bus_grant_n(host_grant_n), .i_coprocessor_bus_grant_n(copro_grant_n),
        .i_board_hold_ack(board_hold_ack), .o_processor_bus_request_n(host_req_a_n),
        .o_dma_owner(owner_a));
    slot_dma_arbiter #(.SYS7M_DIV(1), .COPRO_BUILD(1'b0)) u_slot_dma_arbiter_b (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .bus(bus_b), .i_copro_mode(copro_mode),
        .i_copro_in_charge(copro_in_charge), .i_processor_bus_grant_n(host_grant_n),
        .i_coprocessor_bus_grant_n(copro_grant_n), .i_board_hold_ack(board_hold_ack),
        .o_processor_bus_request_n(host_req_b_n), .o_dma_owner(owner_b));
    slot_arb_sva #(.CARD_SLOT(0)) u_slot_arb_sva (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .slot_bus_request_n(bus_a.slot_bus_request_n), .slot_bus_grant_n(bus_a.slot_bus_grant_n),
        .generic_bus_grant_n(bus_a.generic_bus_grant_n),
        .grant_ack_oe_card(bus_a.grant_ack_oe_card), .own_oe_card(bus_a.own_oe_card),
        .address_strobe_n(bus_a.address_strobe_n),
        .transfer_acknowledge_n(bus_a.transfer_acknowledge_n),
        .grant_acknowledge_n(bus_a.grant_acknowledge_n), .i_copro_mode(copro_mode),
        .i_copro_in_charge(copro_in_charge), .i_processor_bus_grant_n(host_grant_n),
        .i_coprocessor_bus_grant_n(copro_grant_n));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task look(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : look
    // bounded wait, since the grant lags the request by a few ticks
    task req_b(input logic [5:0] req_n, input logic [5:0] exp);
        int n;
        @(posedge clk_sys);
        bus_b.slot_bus_request_n <= req_n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (bus_b.slot_bus_grant_n !== exp && n < 20);
        check({2'h0, bus_b.slot_bus_grant_n}, {2'h0, exp});
    endtask : req_b
    task print_verdict;
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard, well past the 130 or so cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
    initial begin
        {rst_n, dma_start, dma_done, copro_mode, copro_in_charge, host_grant_n} = 6'h00;
        {copro_grant_n, bus_b.grant_ack_oe_card, bus_b.own_oe_card} = 3'h4;
        {bus_a.address_strobe_n, bus_a.transfer_acknowledge_n} = 2'h1;
        {bus_b.address_strobe_n, bus_b.transfer_acknowledge_n} = 2'h3;
        bus_b.slot_bus_request_n = 6'h3f;
        board_hold_ack = 1'b1;
        fails = 0;
        compares = 0;
        repeat (4) @(posedge clk_sys);
        {rst_n, dma_start} <= 2'h3;
        // card granted but held off while the address strobe is busy
        look(12);
        check({bus_a.slot_bus_grant_n, host_req_a_n, bus_owned}, 8'hf8);
        @(posedge clk_sys);
        bus_a.address_strobe_n <= 1'b1;
        look(4);
        // board still pulls acknowledge low, so the card must keep waiting
        check({6'h00, bus_owned, bus_a.grant_acknowledge_n}, 8'h00);
        @(posedge clk_sys);
        board_hold_ack <= 1'b0;
        look(4);
        check({4'h0, bus_owned, bus_a.own_n, bus_a.grant_acknowledge_n, owner_a}, 8'h09);
        @(posedge clk_sys);
        {dma_start, dma_done} <= 2'h1;
        @(posedge clk_sys);
        dma_done <= 1'b0;
        look(1);
        check({5'h0, bus_owned, bus_a.grant_acknowledge_n, bus_a.own_n}, 8'h03);
        look(6);
        check({2'h0, bus_a.slot_bus_grant_n}, 8'h3f);
        // slots k..5 ask together; the lowest index wins
        for (int k = 0; k < 6; k++) begin
            req_b(~(6'h3f << k), ~(6'h01 << k));
            req_b(6'h3f, 6'h3f);
        end
        @(posedge clk_sys);
        {copro_mode, dma_start} <= 2'h3;
        req_b(6'h3c, 6'h3d);
        req_b(6'h37, 6'h37);
        req_b(6'h35, 6'h37);
        look(8);
        check({2'h0, bus_b.slot_bus_grant_n}, 8'h37);
        req_b(6'h3d, 6'h3d);
        @(posedge clk_sys);
        host_grant_n <= 1'b1;
        look(3);
        check({bus_b.slot_bus_grant_n, host_req_b_n, owner_b}, 8'hfc);
        @(posedge clk_sys);
        {host_grant_n, bus_b.own_oe_card} <= 2'h1;
        look(1);
        check({6'h00, bus_b.own_n, owner_b}, 8'h01);
        // the card asks from the coprocessor slot, which is out of the chain
        check({bus_a.slot_bus_grant_n, host_req_a_n, bus_owned}, 8'hfe);
        @(posedge clk_sys);
        {copro_mode, bus_b.own_oe_card, dma_start} <= 3'h0;
        req_b(6'h3f, 6'h3f);
        // back in the chain at level 0, the waiting card now wins the bus
        check({7'h00, bus_owned}, 8'h01);
        @(posedge clk_sys);
        dma_done <= 1'b1;
        @(posedge clk_sys);
        dma_done <= 1'b0;
        // every mix of controller and the two processor grants
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            {copro_in_charge, host_grant_n, copro_grant_n} <= i[2:0];
            @(posedge clk_sys);
            look(1);
            check({6'h00, bus_a.generic_bus_grant_n, bus_b.generic_bus_grant_n},
                {6'h00, (i[2] ? i[0] : i[1]), i[1]});
        end
        print_verdict();
    end
endmodule : tb_top
